// File: pkg/frtc_pkg.sv
// Package for the free running timer with input capture.
// Assumes an APB slave with 32-bit data, one byte register per aligned word.
package frtc_pkg;

  // ----------------------------------------------------------------
  // Register byte addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL_ONE = 8'h00;
  localparam logic [7:0] ADDR_CTRL_TWO = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_CAP1_HI = 8'h0c;
  localparam logic [7:0] ADDR_CAP1_LO = 8'h10;
  localparam logic [7:0] ADDR_CAP2_HI = 8'h14;
  localparam logic [7:0] ADDR_CAP2_LO = 8'h18;
  localparam logic [7:0] ADDR_CNT_HI = 8'h1c;
  localparam logic [7:0] ADDR_CNT_LO = 8'h20;
  localparam logic [7:0] ADDR_ALT_HI = 8'h24;
  localparam logic [7:0] ADDR_ALT_LO = 8'h28;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  // timer_control_one
  localparam int C1_CAP_IRQ_EN = 7;
  localparam int C1_OVF_IRQ_EN = 5;
  localparam int C1_EDGE1 = 1;
  // timer_control_two
  localparam int C2_CLK_SEL_LO = 2;
  localparam int C2_EDGE2 = 1;
  localparam int C2_EXT_EDGE = 0;
  // status_reg
  localparam int ST_CAP1 = 7;
  localparam int ST_CAP2 = 4;
  localparam int ST_OVF = 5;

  // ----------------------------------------------------------------
  // Reset values and counts
  // ----------------------------------------------------------------
  localparam logic [15:0] CNT_RELOAD = 16'hfffc;
  localparam logic [15:0] CNT_TOP = 16'hffff;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [2:0] DIV2_MASK = 3'h1;
  localparam logic [2:0] DIV4_MASK = 3'h3;
  localparam logic [2:0] DIV8_MASK = 3'h7;

  // Clock select encoding
  typedef enum logic [1:0] {
    FRTC_DIV4 = 2'b00,
    FRTC_DIV2 = 2'b01,
    FRTC_DIV8 = 2'b10,
    FRTC_EXT = 2'b11
  } frtc_clk_sel_t;

  // Two-byte read sequence state
  typedef enum logic [0:0] {
    FRTC_RD_IDLE = 1'b0,
    FRTC_RD_HELD = 1'b1
  } frtc_rd_state_t;

  // APB request bundle
  typedef struct packed {
    logic sel;
    logic enable;
    logic write;
    logic [7:0] addr;
    logic [7:0] wdata;
  } frtc_apb_req_t;

endpackage : frtc_pkg

// File: rtl/frtc_timer.sv
// Free running 16-bit timer with two input capture channels, APB slave.
// Assumes pins arrive asynchronously; cpu_halt and cpu_irq_mask are from the core clock.
// Assumes the pins idle low and that every transfer opens with a setup cycle;
// read data is taken in setup, side effects happen only in the access phase.
//
// The APB slave port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps

module frtc_timer #(
  parameter bit EXT_BONDED = 1'b1,
  parameter bit CAP1_BONDED = 1'b1,
  parameter bit CAP2_BONDED = 1'b1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic external_count_input,
  input wire logic capture_pin_1,
  input wire logic capture_pin_2,
  input wire logic cpu_halt,
  input wire logic cpu_irq_mask,
  output logic timer_irq
);

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  frtc_pkg::frtc_apb_req_t req;
  assign req = '{sel: psel, enable: penable, write: pwrite, addr: paddr,
                 wdata: pwdata[7:0]};

  // Access phase qualifiers; every register side effect waits for these
  wire access = req.sel && req.enable;
  wire wr = access && req.write;
  wire rd = access && !req.write;
  wire hit_c1 = (req.addr == frtc_pkg::ADDR_CTRL_ONE);
  wire hit_c2 = (req.addr == frtc_pkg::ADDR_CTRL_TWO);
  wire hit_st = (req.addr == frtc_pkg::ADDR_STATUS);
  wire hit_k1h = (req.addr == frtc_pkg::ADDR_CAP1_HI);
  wire hit_k1l = (req.addr == frtc_pkg::ADDR_CAP1_LO);
  wire hit_k2h = (req.addr == frtc_pkg::ADDR_CAP2_HI);
  wire hit_k2l = (req.addr == frtc_pkg::ADDR_CAP2_LO);
  wire hit_ch = (req.addr == frtc_pkg::ADDR_CNT_HI);
  wire hit_cl = (req.addr == frtc_pkg::ADDR_CNT_LO);
  wire hit_ah = (req.addr == frtc_pkg::ADDR_ALT_HI);
  wire hit_al = (req.addr == frtc_pkg::ADDR_ALT_LO);
  wire mapped = hit_c1 || hit_c2 || hit_st || hit_k1h || hit_k1l || hit_k2h
                || hit_k2l || hit_ch || hit_cl || hit_ah || hit_al;

  // Zero wait states; unmapped addresses answer with an error
  assign pready = 1'b1;
  assign pslverr = access && !mapped;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [2:0] sync1_ff;
  logic [2:0] sync2_ff;
  logic [2:0] hist_ff;
  wire [2:0] pins_raw;

  assign pins_raw = {CAP2_BONDED ? capture_pin_2 : 1'b1,
                     CAP1_BONDED ? capture_pin_1 : 1'b1,
                     EXT_BONDED ? external_count_input : 1'b1};

  // Two stages per pin, then a history stage for edge detection
  // Reset to the pins' idle low level, so leaving reset shows no false edge;
  // an unbonded input shows one rising edge then, harmless as edge bits reset to falling
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_ff <= 3'h0;
      sync2_ff <= 3'h0;
      hist_ff <= 3'h0;
    end else begin
      sync1_ff <= pins_raw;
      sync2_ff <= sync1_ff;
      hist_ff <= sync2_ff;
    end
  end

  // Edge detect with polarity: 1 selects rising, 0 falling
  function automatic logic edge_seen(input logic now, input logic was, input logic rise);
    edge_seen = rise ? (now && !was) : (!now && was);
  endfunction : edge_seen

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  logic [7:0] ctrl_one_ff;
  logic [7:0] ctrl_two_ff;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_one_ff <= frtc_pkg::CTRL_RESET;
      ctrl_two_ff <= frtc_pkg::CTRL_RESET;
    end else begin
      if (wr && hit_c1) ctrl_one_ff <= req.wdata;
      if (wr && hit_c2) ctrl_two_ff <= req.wdata;
    end
  end

  wire frtc_pkg::frtc_clk_sel_t clk_sel =
    frtc_pkg::frtc_clk_sel_t'(ctrl_two_ff[frtc_pkg::C2_CLK_SEL_LO +: 2]);
  wire ovf_irq_en = ctrl_one_ff[frtc_pkg::C1_OVF_IRQ_EN];
  wire cap_irq_en = ctrl_one_ff[frtc_pkg::C1_CAP_IRQ_EN];
  wire ext_rise = ctrl_two_ff[frtc_pkg::C2_EXT_EDGE];
  wire [1:0] cap_rise = {ctrl_two_ff[frtc_pkg::C2_EDGE2], ctrl_one_ff[frtc_pkg::C1_EDGE1]};

  // ----------------------------------------------------------------
  // Prescaler and counter
  // ----------------------------------------------------------------
  logic [2:0] presc_ff;
  logic [15:0] count_ff;
  logic [2:0] div_mask;
  logic tick;

  always_comb begin
    div_mask = frtc_pkg::DIV4_MASK;
    case (clk_sel)
      frtc_pkg::FRTC_DIV2: div_mask = frtc_pkg::DIV2_MASK;
      frtc_pkg::FRTC_DIV8: div_mask = frtc_pkg::DIV8_MASK;
      default: div_mask = frtc_pkg::DIV4_MASK;
    endcase
  end

  // Prescaled tick; external edge when selected
  // Edge chosen by ext edge bit; synchronised, spacing by source
  assign tick = (clk_sel == frtc_pkg::FRTC_EXT)
                ? edge_seen(sync2_ff[0], hist_ff[0], ext_rise)
                : ((presc_ff & div_mask) == div_mask);

  // Reload beats a step in the same cycle, so the write always lands on FFFCh
  wire cnt_reload = wr && (hit_cl || hit_al);
  wire cnt_step = tick && !cpu_halt;
  wire wrap = cnt_step && !cnt_reload && (count_ff == frtc_pkg::CNT_TOP);

  // Prescaler free from reset, so twin instances stay in step
  // Halt freezes prescaler and counter; wait has no input here
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      presc_ff <= 3'h0;
    end else if (!cpu_halt) begin
      presc_ff <= presc_ff + 3'h1;
    end
  end

  // Reset value; low byte write reloads; count up
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_ff <= frtc_pkg::CNT_RELOAD;
    end else if (cnt_reload) begin
      count_ff <= frtc_pkg::CNT_RELOAD;
    end else if (cnt_step) begin
      count_ff <= count_ff + 16'h0001;
    end
  end

  // ----------------------------------------------------------------
  // Two-byte read buffers for counter views
  // ----------------------------------------------------------------
  frtc_pkg::frtc_rd_state_t cnt_rd_ff;
  frtc_pkg::frtc_rd_state_t alt_rd_ff;
  logic [7:0] cnt_lo_buf_ff;
  logic [7:0] alt_lo_buf_ff;
  logic [15:0] cnt_snap_ff;
  wire rd_setup = req.sel && !req.enable && !req.write;

  // Count as shown in the setup cycle; the high byte on the bus comes from the
  // same edge, so the buffered low byte always pairs with it across a carry
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_snap_ff <= frtc_pkg::CNT_RELOAD;
    end else if (rd_setup) begin
      cnt_snap_ff <= count_ff;
    end
  end

  // Primary view: high read latches low byte; re-reading high keeps it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_rd_ff <= frtc_pkg::FRTC_RD_IDLE;
      cnt_lo_buf_ff <= 8'h00;
    end else begin
      case (cnt_rd_ff)
        frtc_pkg::FRTC_RD_IDLE: if (rd && hit_ch) begin
          cnt_rd_ff <= frtc_pkg::FRTC_RD_HELD;
          cnt_lo_buf_ff <= cnt_snap_ff[7:0];
        end
        default: if (rd && hit_cl) cnt_rd_ff <= frtc_pkg::FRTC_RD_IDLE;
      endcase
    end
  end

  // Alternate view: own buffer, so the two sequences may interleave
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      alt_rd_ff <= frtc_pkg::FRTC_RD_IDLE;
      alt_lo_buf_ff <= 8'h00;
    end else begin
      case (alt_rd_ff)
        frtc_pkg::FRTC_RD_IDLE: if (rd && hit_ah) begin
          alt_rd_ff <= frtc_pkg::FRTC_RD_HELD;
          alt_lo_buf_ff <= cnt_snap_ff[7:0];
        end
        default: if (rd && hit_al) alt_rd_ff <= frtc_pkg::FRTC_RD_IDLE;
      endcase
    end
  end

  // Lone low read shows the live low byte
  wire [7:0] cnt_lo_view = (cnt_rd_ff == frtc_pkg::FRTC_RD_HELD) ? cnt_lo_buf_ff
                                                                 : count_ff[7:0];
  wire [7:0] alt_lo_view = (alt_rd_ff == frtc_pkg::FRTC_RD_HELD) ? alt_lo_buf_ff
                                                                 : count_ff[7:0];

  // ----------------------------------------------------------------
  // Input capture channels
  // ----------------------------------------------------------------
  logic [15:0] cap_val_ff [2];
  logic [1:0] cap_block_ff;
  wire [1:0] cap_hi_rd = {rd && hit_k2h, rd && hit_k1h};
  wire [1:0] cap_lo_rd = {rd && hit_k2l, rd && hit_k1l};
  wire [1:0] cap_lo_acc = {access && hit_k2l, access && hit_k1l};
  wire [1:0] cap_evt;

  // Per-channel edge; blocked after high byte read
  assign cap_evt[0] = edge_seen(sync2_ff[1], hist_ff[1], cap_rise[0]) && !cap_block_ff[0];
  assign cap_evt[1] = edge_seen(sync2_ff[2], hist_ff[2], cap_rise[1]) && !cap_block_ff[1];

  // Copy counter on capture; no write path exists
  // A capture at the edge of the high byte read still lands; blocking starts after it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cap_val_ff[0] <= 16'h0000;
      cap_val_ff[1] <= 16'h0000;
      cap_block_ff <= 2'b00;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (cap_evt[i]) cap_val_ff[i] <= count_ff;
        // Block from high read until low read
        if (cap_lo_rd[i]) cap_block_ff[i] <= 1'b0;
        else if (cap_hi_rd[i]) cap_block_ff[i] <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Status flags with two-step clear
  // ----------------------------------------------------------------
  logic ovf_ff;
  logic [1:0] cap_flag_ff;
  logic ovf_armed_ff;
  logic [1:0] cap_armed_ff;
  logic [31:0] prdata_ff;
  wire st_rd = rd && hit_st;
  // Flags as software saw them in the status byte on the bus
  wire [1:0] cap_seen = {prdata_ff[frtc_pkg::ST_CAP2], prdata_ff[frtc_pkg::ST_CAP1]};
  wire ovf_seen = prdata_ff[frtc_pkg::ST_OVF];

  // Set always wins over a clear in the same cycle. Arming uses the byte shown,
  // so a flag raised during the status read itself is never cleared unseen
  // Wrap sets overflow; read-status then primary low access clears
  // Alternate low access never touches the overflow flag
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ovf_ff <= 1'b0;
      ovf_armed_ff <= 1'b0;
    end else begin
      if (wrap) ovf_ff <= 1'b1;
      else if (ovf_armed_ff && access && hit_cl) ovf_ff <= 1'b0;
      if (st_rd && ovf_seen) ovf_armed_ff <= 1'b1;
      else if (access && hit_cl) ovf_armed_ff <= 1'b0;
    end
  end

  // Capture sets flag; read-status then capture low access clears
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cap_flag_ff <= 2'b00;
      cap_armed_ff <= 2'b00;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (cap_evt[i]) cap_flag_ff[i] <= 1'b1;
        else if (cap_armed_ff[i] && cap_lo_acc[i]) cap_flag_ff[i] <= 1'b0;
        if (st_rd && cap_seen[i]) cap_armed_ff[i] <= 1'b1;
        else if (cap_lo_acc[i]) cap_armed_ff[i] <= 1'b0;
      end
    end
  end

  // Overflow request gated; capture request gated, flags stay pending
  // Level request: it drops only on a flag clear, an enable write or the mask rising
  assign timer_irq = !cpu_irq_mask && ((ovf_irq_en && ovf_ff)
                     || (cap_irq_en && (|cap_flag_ff)));

  // ----------------------------------------------------------------
  // Read data mux
  // ----------------------------------------------------------------
  logic [7:0] status_view;
  always_comb begin
    status_view = 8'h00;
    status_view[frtc_pkg::ST_CAP1] = cap_flag_ff[0];
    status_view[frtc_pkg::ST_CAP2] = cap_flag_ff[1];
    status_view[frtc_pkg::ST_OVF] = ovf_ff;
  end

  logic [7:0] rd_byte;
  always_comb begin
    if (hit_c1) rd_byte = ctrl_one_ff;
    else if (hit_c2) rd_byte = ctrl_two_ff;
    else if (hit_st) rd_byte = status_view;
    else if (hit_k1h) rd_byte = cap_val_ff[0][15:8];
    else if (hit_k1l) rd_byte = cap_val_ff[0][7:0];
    else if (hit_k2h) rd_byte = cap_val_ff[1][15:8];
    else if (hit_k2l) rd_byte = cap_val_ff[1][7:0];
    else if (hit_ch || hit_ah) rd_byte = count_ff[15:8];
    else if (hit_cl) rd_byte = cnt_lo_view;
    else if (hit_al) rd_byte = alt_lo_view;
    else rd_byte = 8'h00;
  end

  // Read data is registered in the setup cycle, so the byte stands unchanged
  // through the access even while the counter moves underneath it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff <= 32'h0000_0000;
    end else if (rd_setup) begin
      prdata_ff <= {24'h000000, rd_byte};
    end
  end

  // Upper bits read zero; the last byte read holds between transfers
  assign prdata = prdata_ff;

endmodule : frtc_timer

// File: verification/frtc_timer_assertions.sv
// Checker for the timer's bus port and interrupt output.
// Bound to frtc_timer; sees its ports only, one clock domain.
`timescale 1ns/1ps
module frtc_timer_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic cpu_halt,
  input wire logic cpu_irq_mask,
  input wire logic timer_irq
);
  // ----------------------------------------------------------------
  // Helper logic and properties
  // ----------------------------------------------------------------
  logic acc, rd_alt, nxt_vld, vld_ff, halt_ff;
  logic [7:0] hold_ff;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Halt must have settled a cycle, else a last tick may land
  assign acc = psel && penable;
  assign rd_alt = acc && !pwrite && paddr == frtc_pkg::ADDR_ALT_HI && halt_ff;
  assign nxt_vld = cpu_halt && !(acc && pwrite) && (vld_ff || rd_alt);
  // First frozen reading kept until halt ends or a write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      halt_ff <= 1'b0;
      vld_ff <= 1'b0;
      hold_ff <= 8'h00;
    end else begin
      halt_ff <= cpu_halt;
      vld_ff <= nxt_vld;
      if (rd_alt && !vld_ff) hold_ff <= prdata[7:0];
    end
  end
  ready_high_a: assert property (pready) else $error("pready low");
  err_phase_a: assert property (pslverr |-> acc) else $error("pslverr outside access");
  upper_zero_a: assert property (acc && !pwrite |-> prdata[31:8] == 24'h0)
    else $error("upper read data not zero");
  bad_addr_a: assert property (acc && paddr > 8'h28 |-> pslverr && (pwrite || prdata == 32'h0))
    else $error("unmapped access not refused");
  good_addr_a: assert property (acc && paddr <= 8'h28 && paddr[1:0] == 2'b00 |-> !pslverr)
    else $error("mapped access refused");
  irq_mask_a: assert property (cpu_irq_mask |-> !timer_irq)
    else $error("interrupt while masked");
  irq_fall_a: assert property ($fell(timer_irq) |-> $past(acc) || cpu_irq_mask)
    else $error("interrupt dropped with no cause");
  halt_hold_a: assert property (rd_alt && vld_ff |-> prdata[7:0] == hold_ff)
    else $error("count moved during halt");
  cover property (acc && pslverr);
  cover property ($rose(timer_irq));
  cover property (rd_alt && vld_ff);
endmodule : frtc_timer_checker

bind frtc_timer frtc_timer_checker frtc_timer_checker_i (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .cpu_halt(cpu_halt), .cpu_irq_mask(cpu_irq_mask),
  .timer_irq(timer_irq));

// File: verification/frtc_pin_model.sv
// Pin-side model: external count pin and two capture pins.
// Driven by the bench through set_pin; all pins start low.
`timescale 1ns/1ps
module frtc_pin_model (
  input wire logic pclk,
  output logic ext_pin,
  output logic cap1_pin,
  output logic cap2_pin
);
  initial begin
    ext_pin = 1'b0;
    cap1_pin = 1'b0;
    cap2_pin = 1'b0;
  end
  task automatic set_pin(input int which, input logic v);
    @(posedge pclk);
    case (which)
      0: ext_pin <= v;
      1: cap1_pin <= v;
      default: cap2_pin <= v;
    endcase
    repeat (8) @(posedge pclk);
  endtask : set_pin
endmodule : frtc_pin_model

// File: verification/testbench.sv
// Self-checking bench for frtc_timer over APB with a pin model.
// Assumes zero wait states are allowed but waits on pready anyway.
`timescale 1ns/1ps
module testbench;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic cpu_halt = 1'b1;
  logic cpu_irq_mask = 1'b1;
  logic [31:0] prdata;
  logic pready, pslverr, timer_irq, ext_pin, cap1, cap2, err;
  logic [7:0] rd;
  logic [15:0] v, c, d;
  int miscompares = 0;
  int checks_done = 0;
  int cycles = 0;
  int w;
  integer seed = 32'he0a2b95c;
  always #25 pclk = ~pclk;
  frtc_timer frtc_timer_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .external_count_input(ext_pin), .capture_pin_1(cap1),
    .capture_pin_2(cap2), .cpu_halt(cpu_halt), .cpu_irq_mask(cpu_irq_mask),
    .timer_irq(timer_irq));
  frtc_pin_model frtc_pin_model_i (.pclk(pclk), .ext_pin(ext_pin), .cap1_pin(cap1),
    .cap2_pin(cap2));
  // ----------------------------------------------------------------
  // Tasks and functions
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : give_verdict
  // Setup, access until pready, release after the sampling edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] dat);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h0, dat};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) miscompares++;
    rd = prdata[7:0];
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rd16(input logic [7:0] a);
    apb(1'b0, a, 8'h00);
    v[15:8] = rd;
    apb(1'b0, a + 8'h04, 8'h00);
    v[7:0] = rd;
  endtask : rd16
  function automatic int div_of(input int sel);
    if (sel == 1) return 2;
    if (sel == 2) return 8;
    return 4;
  endfunction : div_of
  // Hang guard
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      give_verdict();
    end
  end
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, frtc_pkg::ADDR_CTRL_TWO, 8'h00);
    check(rd, frtc_pkg::CTRL_RESET);
    apb(1'b0, 8'h2c, 8'h00);
    check({err, rd}, 9'h100);
    rd16(frtc_pkg::ADDR_CNT_HI);
    check(v, frtc_pkg::CNT_RELOAD);
    apb(1'b1, frtc_pkg::ADDR_CAP1_HI, 8'h77);
    rd16(frtc_pkg::ADDR_CAP1_HI);
    check(v, 16'h0000);
    apb(1'b1, frtc_pkg::ADDR_CTRL_ONE, 8'h20);
    // Each divider over a random span, counter frozen to read
    for (int s = 0; s < 3; s++) begin
      w = 20 + ($random(seed) & 15);
      apb(1'b1, frtc_pkg::ADDR_CTRL_TWO, 8'(s << 2));
      apb(1'b1, frtc_pkg::ADDR_CNT_LO, 8'h5a);
      cpu_halt <= 1'b0;
      repeat (w * div_of(s)) @(posedge pclk);
      cpu_halt <= 1'b1;
      rd16(frtc_pkg::ADDR_ALT_HI);
      d = v - frtc_pkg::CNT_RELOAD;
      check(d >= w - 2 && d <= w + 2, 1'b1);
    end
    check(timer_irq, 1'b0);
    cpu_irq_mask <= 1'b0;
    apb(1'b0, frtc_pkg::ADDR_STATUS, 8'h00);
    check(rd[frtc_pkg::ST_OVF], 1'b1);
    check(timer_irq, 1'b1);
    apb(1'b0, frtc_pkg::ADDR_ALT_LO, 8'h00);
    apb(1'b0, frtc_pkg::ADDR_STATUS, 8'h00);
    check(rd[frtc_pkg::ST_OVF], 1'b1);
    apb(1'b0, frtc_pkg::ADDR_CNT_LO, 8'h00);
    apb(1'b0, frtc_pkg::ADDR_STATUS, 8'h00);
    check({rd[frtc_pkg::ST_OVF], timer_irq}, 2'b00);
    // Low byte buffered across a second high read
    apb(1'b1, frtc_pkg::ADDR_ALT_LO, 8'h00);
    apb(1'b0, frtc_pkg::ADDR_CNT_HI, 8'h00);
    cpu_halt <= 1'b0;
    repeat (40) @(posedge pclk);
    cpu_halt <= 1'b1;
    apb(1'b0, frtc_pkg::ADDR_CNT_HI, 8'h00);
    check(rd, 8'h00);
    apb(1'b0, frtc_pkg::ADDR_CNT_LO, 8'h00);
    check(rd, 8'hfc);
    rd16(frtc_pkg::ADDR_ALT_HI);
    c = v;
    apb(1'b0, frtc_pkg::ADDR_CNT_LO, 8'h00);
    check(rd, c[7:0]);
    // Second full read in the same halt must see the frozen count
    rd16(frtc_pkg::ADDR_ALT_HI);
    check(v, c);
    // Captures: channel one rising, channel two falling
    apb(1'b1, frtc_pkg::ADDR_CTRL_ONE, 8'h82);
    frtc_pin_model_i.set_pin(1, 1'b1);
    frtc_pin_model_i.set_pin(2, 1'b1);
    apb(1'b0, frtc_pkg::ADDR_STATUS, 8'h00);
    check({rd & 8'h90, timer_irq}, {8'h80, 1'b1});
    frtc_pin_model_i.set_pin(2, 1'b0);
    apb(1'b0, frtc_pkg::ADDR_STATUS, 8'h00);
    check(rd & 8'h90, 8'h90);
    rd16(frtc_pkg::ADDR_CAP1_HI);
    check(v, c);
    rd16(frtc_pkg::ADDR_CAP2_HI);
    check(v, c);
    apb(1'b0, frtc_pkg::ADDR_STATUS, 8'h00);
    check({rd & 8'h90, timer_irq}, 9'h000);
    // High read blocks a capture until the low read
    apb(1'b1, frtc_pkg::ADDR_CNT_LO, 8'h00);
    apb(1'b0, frtc_pkg::ADDR_CAP1_HI, 8'h00);
    frtc_pin_model_i.set_pin(1, 1'b0);
    frtc_pin_model_i.set_pin(1, 1'b1);
    apb(1'b0, frtc_pkg::ADDR_CAP1_LO, 8'h00);
    check(rd, c[7:0]);
    apb(1'b0, frtc_pkg::ADDR_STATUS, 8'h00);
    check(rd & 8'h90, 8'h00);
    frtc_pin_model_i.set_pin(1, 1'b0);
    frtc_pin_model_i.set_pin(1, 1'b1);
    rd16(frtc_pkg::ADDR_CAP1_HI);
    check(v, frtc_pkg::CNT_RELOAD);
    // External clock, rising then falling edge
    apb(1'b1, frtc_pkg::ADDR_CTRL_TWO, 8'h0d);
    cpu_halt <= 1'b0;
    apb(1'b1, frtc_pkg::ADDR_CNT_LO, 8'h00);
    frtc_pin_model_i.set_pin(0, 1'b1);
    apb(1'b0, frtc_pkg::ADDR_ALT_LO, 8'h00);
    check(rd, 8'hfd);
    frtc_pin_model_i.set_pin(0, 1'b0);
    apb(1'b1, frtc_pkg::ADDR_CTRL_TWO, 8'h0c);
    frtc_pin_model_i.set_pin(0, 1'b1);
    apb(1'b0, frtc_pkg::ADDR_ALT_LO, 8'h00);
    check(rd, 8'hfd);
    frtc_pin_model_i.set_pin(0, 1'b0);
    apb(1'b0, frtc_pkg::ADDR_ALT_LO, 8'h00);
    check(rd, 8'hfe);
    give_verdict();
  end
endmodule : testbench
